// ==== design/hpsq_dev_end.sv ====
// Device end: slot registers, register ports and automatic slot sequencer.
`timescale 1ns/1ps
module hpsq_dev_end (
  hpsq_link_if.dev link,
  input wire logic pclk,
  input wire logic presetn,
  input wire logic serial_mode,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_oe,
  input wire logic system_fast_clock_enable,
  input wire logic [1:0] card_fast_capable,
  output logic [3:0] slot_power_out,
  output logic [3:0] slot_reset_out,
  output logic [3:0] slot_clock_enable_out,
  output logic [3:0] bus_switch_enable_out,
  output logic [3:0] wide_switch_enable_out,
  output logic [3:0] slot_wide_request
);
  localparam int NP = $bits(hpsq_pkg::hpsq_pins_t);
  logic [NP-1:0] pin_raw;
  logic [NP-1:0] pin_s1_q;
  logic [NP-1:0] pin_s2_q;
  logic [NP-1:0] pin_s3_q;
  logic [NP-1:0] pin_q;
  hpsq_pkg::hpsq_pins_t pin;
  logic [2:0] boot_q;
  logic sys66_q;
  logic prot_q;
  hpsq_pkg::hpsq_seq_t seq_q;
  hpsq_pkg::hpsq_seq_t mode_q;
  hpsq_pkg::hpsq_auto_t st_q;
  logic [1:0] cur_q;
  logic conn_q;
  logic [3:0] pend_q;
  logic [3:0] dir_q;
  logic [3:0] busctl_q;
  logic par_hit;
  logic par_hit_q;
  logic wr_en;
  logic [4:0] wr_addr;
  logic [7:0] wr_data;
  logic [4:0] rd_addr;
  logic [7:0] rd_val;
  logic [4:0] ser_ptr;
  logic [7:0] ser_wdata;
  logic ser_we;
  logic [3:0] trig;
  logic [3:0] take;
  logic bus_idle;

  function automatic logic hits(input logic [4:0] a, input int slot, input logic [2:0] r);
    hits = (a[4:3] == 2'(slot)) && (a[2:0] == r);
  endfunction : hits

  ////////////////////////////////////////////////////////////////////////////
  // Every pin passes four flops; a bit changes only when stages two and three agree.
  assign pin_raw = {link.addr, link.data_bus, serial_mode, scl, sda_in,
                    system_fast_clock_enable, card_fast_capable, link.idle_grant,
                    link.frame_n, link.irdy_n, link.cs_n, link.rd_n, link.wr_n};
  assign pin = pin_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= hpsq_pkg::PIN_RST;
      pin_s2_q <= hpsq_pkg::PIN_RST;
      pin_s3_q <= hpsq_pkg::PIN_RST;
      pin_q <= hpsq_pkg::PIN_RST;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_q <= (~(pin_s2_q ^ pin_s3_q) & pin_s3_q) | ((pin_s2_q ^ pin_s3_q) & pin_q);
    end
  end

  // The strap keeps tracking the pin until the counter stops after reset release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_q <= 3'h0;
      sys66_q <= 1'b0;
    end else if (boot_q != hpsq_pkg::STRAP_CYCLES) begin
      boot_q <= boot_q + 3'h1;
      sys66_q <= pin.sysfast;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  hpsq_i2c_slave u_ser (
    .pclk(pclk),
    .presetn(presetn),
    .en(pin.smode),
    .scl(pin.scl),
    .sda(pin.sda),
    .rdata(link.rdata),
    .ptr(ser_ptr),
    .wdata(ser_wdata),
    .we(ser_we),
    .sda_oe(sda_oe)
  );

  assign par_hit = ~pin.smode & ~pin.cs_n & ~pin.wr_n;
  assign wr_en = pin.smode ? ser_we : (par_hit & ~par_hit_q);
  assign wr_addr = pin.smode ? ser_ptr : pin.addr;
  assign wr_data = pin.smode ? ser_wdata : pin.data;
  assign rd_addr = pin.smode ? ser_ptr : pin.addr;

  always_comb begin
    rd_val = 8'h00;
    if (rd_addr[2:0] == hpsq_pkg::REG_GCFG) begin
      rd_val = {hpsq_pkg::REV_ID, seq_q, sys66_q, prot_q};
    end
    for (int i = 0; i < hpsq_pkg::NSLOT; i++) begin
      if (hits(rd_addr, i, hpsq_pkg::REG_STAT)) begin
        rd_val = {6'h00, pend_q[i] | (st_q != hpsq_pkg::AS_IDLE && cur_q == 2'(i)),
                  (i < 2) && slot_power_out[i] && pin.cardfast[i % 2]};
      end
      if (hits(rd_addr, i, hpsq_pkg::REG_CTRL)) begin
        rd_val = {2'b00, busctl_q[i], ~wide_switch_enable_out[i], slot_wide_request[i],
                  ~slot_clock_enable_out[i], ~slot_reset_out[i], slot_power_out[i]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_hit_q <= 1'b0;
      link.rdata <= 8'h00;
      link.rdata_oe <= 1'b0;
    end else begin
      par_hit_q <= par_hit;
      link.rdata <= rd_val;
      link.rdata_oe <= ~pin.smode & ~pin.cs_n & ~pin.rd_n;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_q <= hpsq_pkg::SEQ_MANUAL;
      prot_q <= 1'b0;
    end else if (wr_en && wr_addr[2:0] == hpsq_pkg::REG_GCFG) begin
      seq_q <= hpsq_pkg::hpsq_seq_t'(wr_data[hpsq_pkg::GB_SEQ +: 2]);
      prot_q <= wr_data[hpsq_pkg::GB_PROT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // A connect-bit change in an automatic mode queues that slot; set wins over take.
  always_comb begin
    for (int i = 0; i < hpsq_pkg::NSLOT; i++) begin
      trig[i] = wr_en && hits(wr_addr, i, hpsq_pkg::REG_CTRL) &&
                (seq_q == hpsq_pkg::SEQ_AUTO1 || seq_q == hpsq_pkg::SEQ_AUTO2) &&
                (wr_data[hpsq_pkg::CB_BUS] != busctl_q[i]);
      take[i] = (st_q == hpsq_pkg::AS_IDLE) && pend_q[i] && !(|(pend_q & ((4'h1 << i) - 4'h1)));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 4'h0;
      dir_q <= 4'h0;
    end else begin
      pend_q <= (pend_q & ~take) | trig;
      for (int i = 0; i < hpsq_pkg::NSLOT; i++) begin
        if (trig[i]) begin
          dir_q[i] <= ~wr_data[hpsq_pkg::CB_BUS];
        end
      end
    end
  end

  assign bus_idle = pin.grant & pin.frame_n & pin.irdy_n;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= hpsq_pkg::AS_IDLE;
      cur_q <= 2'h0;
      conn_q <= 1'b0;
      mode_q <= hpsq_pkg::SEQ_MANUAL;
      link.idle_request <= 1'b0;
    end else begin
      unique case (st_q)
        hpsq_pkg::AS_IDLE: begin
          for (int i = hpsq_pkg::NSLOT - 1; i >= 0; i--) begin
            if (take[i]) begin
              cur_q <= 2'(i);
              conn_q <= dir_q[i];
              mode_q <= seq_q;
              link.idle_request <= 1'b1;
              st_q <= hpsq_pkg::AS_REQ;
            end
          end
        end
        hpsq_pkg::AS_REQ: begin
          if (bus_idle) begin
            st_q <= hpsq_pkg::AS_STEP1;
          end
        end
        hpsq_pkg::AS_STEP1: st_q <= hpsq_pkg::AS_STEP2;
        hpsq_pkg::AS_STEP2: st_q <= hpsq_pkg::AS_DONE;
        hpsq_pkg::AS_DONE: begin
          link.idle_request <= 1'b0;
          st_q <= hpsq_pkg::AS_IDLE;
        end
        default: st_q <= hpsq_pkg::AS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // After reset the slots are unpowered, held in reset and off the bus, but the wide switch starts at the level a connect sets.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_power_out <= hpsq_pkg::SLOT_RST_OFF;
      slot_reset_out <= hpsq_pkg::SLOT_RST_ON;
      slot_clock_enable_out <= hpsq_pkg::SLOT_RST_OFF;
      bus_switch_enable_out <= hpsq_pkg::SLOT_RST_OFF;
      wide_switch_enable_out <= hpsq_pkg::SLOT_RST_OFF;
      slot_wide_request <= hpsq_pkg::SLOT_RST_ON;
      busctl_q <= hpsq_pkg::SLOT_RST_ON;
    end else begin
      for (int i = 0; i < hpsq_pkg::NSLOT; i++) begin
        if (wr_en && hits(wr_addr, i, hpsq_pkg::REG_CTRL)) begin
          slot_power_out[i] <= wr_data[hpsq_pkg::CB_PWR];
          slot_reset_out[i] <= ~wr_data[hpsq_pkg::CB_RST];
          slot_clock_enable_out[i] <= ~wr_data[hpsq_pkg::CB_CLK];
          slot_wide_request[i] <= wr_data[hpsq_pkg::CB_WREQ];
          wide_switch_enable_out[i] <= ~wr_data[hpsq_pkg::CB_WSW];
          busctl_q[i] <= wr_data[hpsq_pkg::CB_BUS];
          if (seq_q == hpsq_pkg::SEQ_MANUAL || seq_q == hpsq_pkg::SEQ_RSVD) begin
            bus_switch_enable_out[i] <= ~wr_data[hpsq_pkg::CB_BUS];
          end
        end
        if (cur_q == 2'(i) && st_q == hpsq_pkg::AS_STEP1) begin
          if (!conn_q) begin
            bus_switch_enable_out[i] <= 1'b0;
            slot_clock_enable_out[i] <= 1'b0;
            wide_switch_enable_out[i] <= 1'b1;
          end else if (mode_q == hpsq_pkg::SEQ_AUTO1) begin
            bus_switch_enable_out[i] <= 1'b1;
          end else begin
            slot_reset_out[i] <= 1'b0;
          end
        end
        if (cur_q == 2'(i) && st_q == hpsq_pkg::AS_STEP2) begin
          if (!conn_q) begin
            slot_power_out[i] <= 1'b0;
          end else begin
            slot_reset_out[i] <= 1'b0;
            slot_wide_request[i] <= 1'b1;
            wide_switch_enable_out[i] <= 1'b0;
            bus_switch_enable_out[i] <= 1'b1;
          end
        end
      end
    end
  end
endmodule : hpsq_dev_end

// ==== design/hpsq_host_end.sv ====
// Host end: APB command registers, ISA-style register cycles and idle arbiter.
`timescale 1ns/1ps
module hpsq_host_end (
  hpsq_link_if.host link,
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pci_frame_n,
  input wire logic pci_irdy_n
);
  localparam int NH = $bits(hpsq_pkg::hpsq_hpins_t);
  logic [NH-1:0] h_s1_q;
  logic [NH-1:0] h_s2_q;
  logic [NH-1:0] h_s3_q;
  logic [NH-1:0] h_q;
  hpsq_pkg::hpsq_hpins_t hp;
  hpsq_pkg::hpsq_isa_t st_q;
  logic [3:0] cnt_q;
  logic wr_q;
  logic arb_en_q;
  logic [7:0] rdbuf_q;
  logic acc;
  logic launch;

  assign hp = h_q;
  assign acc = psel & penable & pready;
  assign launch = acc & pwrite & (paddr == hpsq_pkg::APB_CMD) & (st_q == hpsq_pkg::H_IDLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h_s1_q <= hpsq_pkg::HPIN_RST;
      h_s2_q <= hpsq_pkg::HPIN_RST;
      h_s3_q <= hpsq_pkg::HPIN_RST;
      h_q <= hpsq_pkg::HPIN_RST;
    end else begin
      h_s1_q <= {pci_frame_n, pci_irdy_n, link.idle_request, link.data_bus};
      h_s2_q <= h_s1_q;
      h_s3_q <= h_s2_q;
      h_q <= (~(h_s2_q ^ h_s3_q) & h_s3_q) | ((h_s2_q ^ h_s3_q) & h_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      arb_en_q <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr != hpsq_pkg::APB_CMD) &
                 (paddr != hpsq_pkg::APB_STAT) & (paddr != hpsq_pkg::APB_ARB);
      prdata <= 32'h00000000;
      if (paddr == hpsq_pkg::APB_STAT) begin
        prdata <= {16'h0000, rdbuf_q, 7'h00, st_q != hpsq_pkg::H_IDLE};
      end
      if (paddr == hpsq_pkg::APB_ARB) begin
        prdata <= {31'h00000000, arb_en_q};
      end
      if (acc && pwrite && paddr == hpsq_pkg::APB_ARB) begin
        arb_en_q <= pwdata[0];
      end
    end
  end

  // Grant follows the request only while software allows it; bus idle levels pass through.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.idle_grant <= 1'b0;
      link.frame_n <= 1'b1;
      link.irdy_n <= 1'b1;
    end else begin
      link.idle_grant <= arb_en_q & hp.idle_req;
      link.frame_n <= hp.frame_n;
      link.irdy_n <= hp.irdy_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wait states are stretched so the device's pin filter and read path settle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= hpsq_pkg::H_IDLE;
      cnt_q <= 4'h0;
      wr_q <= 1'b0;
      rdbuf_q <= 8'h00;
      link.cs_n <= 1'b1;
      link.rd_n <= 1'b1;
      link.wr_n <= 1'b1;
      link.addr <= 5'h00;
      link.hdata <= 8'h00;
      link.hdata_oe <= 1'b0;
    end else begin
      unique case (st_q)
        hpsq_pkg::H_IDLE: begin
          if (launch) begin
            link.addr <= pwdata[4:0];
            link.hdata <= pwdata[15:8];
            link.hdata_oe <= pwdata[hpsq_pkg::CMD_WRITE];
            wr_q <= pwdata[hpsq_pkg::CMD_WRITE];
            link.cs_n <= 1'b0;
            st_q <= hpsq_pkg::H_SETUP;
          end
        end
        hpsq_pkg::H_SETUP: begin
          link.wr_n <= ~wr_q;
          link.rd_n <= wr_q;
          cnt_q <= 4'h0;
          st_q <= hpsq_pkg::H_STROBE;
        end
        hpsq_pkg::H_STROBE: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == hpsq_pkg::ISA_STROBE_LAST) begin
            if (!wr_q) begin
              rdbuf_q <= hp.data;
            end
            link.wr_n <= 1'b1;
            link.rd_n <= 1'b1;
            link.cs_n <= 1'b1;
            link.hdata_oe <= 1'b0;
            cnt_q <= 4'h0;
            st_q <= hpsq_pkg::H_RECOV;
          end
        end
        hpsq_pkg::H_RECOV: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == hpsq_pkg::ISA_RECOVER_LAST) begin
            st_q <= hpsq_pkg::H_IDLE;
          end
        end
      endcase
    end
  end
endmodule : hpsq_host_end

// ==== design/hpsq_i2c_slave.sv ====
// Two-wire serial register slave with auto-incrementing register pointer.
`timescale 1ns/1ps
module hpsq_i2c_slave (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic scl,
  input wire logic sda,
  input wire logic [7:0] rdata,
  output logic [4:0] ptr,
  output logic [7:0] wdata,
  output logic we,
  output logic sda_oe
);
  hpsq_pkg::hpsq_i2c_t st_q;
  logic scl_q;
  logic sda_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic ack_q;
  logic rw_q;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  assign rise = scl & ~scl_q;
  assign fall = ~scl & scl_q;
  assign start = scl & scl_q & sda_q & ~sda;
  assign stop = scl & scl_q & ~sda_q & sda;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= hpsq_pkg::I2C_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ack_q <= 1'b0;
      rw_q <= 1'b0;
      ptr <= 5'h00;
      wdata <= 8'h00;
      we <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      we <= 1'b0;
      if (!en || stop) begin
        st_q <= hpsq_pkg::I2C_IDLE;
        ack_q <= 1'b0;
        sda_oe <= 1'b0;
      end else if (start) begin
        st_q <= hpsq_pkg::I2C_DEV;
        cnt_q <= 4'h0;
        ack_q <= 1'b0;
        sda_oe <= 1'b0;
      end else if (st_q != hpsq_pkg::I2C_IDLE && rise) begin
        if (ack_q) begin
          if (st_q == hpsq_pkg::I2C_RD && sda) begin
            st_q <= hpsq_pkg::I2C_IDLE;
          end
        end else begin
          cnt_q <= cnt_q + 4'h1;
          if (st_q != hpsq_pkg::I2C_RD) begin
            sh_q <= {sh_q[6:0], sda};
          end
        end
      end else if (st_q != hpsq_pkg::I2C_IDLE && fall) begin
        if (!ack_q && cnt_q == 4'h8) begin
          ack_q <= 1'b1;
          cnt_q <= 4'h0;
          sda_oe <= (st_q != hpsq_pkg::I2C_RD);
          unique case (st_q)
            hpsq_pkg::I2C_DEV: begin
              rw_q <= sh_q[0];
              if (sh_q[7:1] != hpsq_pkg::SER_ADDR) begin
                st_q <= hpsq_pkg::I2C_IDLE;
                sda_oe <= 1'b0;
              end
            end
            hpsq_pkg::I2C_PTR: ptr <= sh_q[4:0];
            hpsq_pkg::I2C_WR: begin
              wdata <= sh_q;
              we <= 1'b1;
            end
            hpsq_pkg::I2C_RD: ptr <= ptr + 5'h01;
            hpsq_pkg::I2C_IDLE: ;
          endcase
        end else if (ack_q) begin
          ack_q <= 1'b0;
          sda_oe <= 1'b0;
          if (st_q == hpsq_pkg::I2C_DEV) begin
            st_q <= rw_q ? hpsq_pkg::I2C_RD : hpsq_pkg::I2C_PTR;
          end
          if (st_q == hpsq_pkg::I2C_PTR) begin
            st_q <= hpsq_pkg::I2C_WR;
          end
          if (st_q == hpsq_pkg::I2C_WR) begin
            ptr <= ptr + 5'h01;
          end
          if ((st_q == hpsq_pkg::I2C_DEV && rw_q) || st_q == hpsq_pkg::I2C_RD) begin
            sda_oe <= ~rdata[7];
            sh_q <= {rdata[6:0], 1'b0};
          end
        end else if (st_q == hpsq_pkg::I2C_RD) begin
          sda_oe <= ~sh_q[7];
          sh_q <= {sh_q[6:0], 1'b0};
        end
      end
    end
  end
endmodule : hpsq_i2c_slave

// ==== design/hpsq_link_if.sv ====
// Interface joining the register port and idle handshake of host and device.
`timescale 1ns/1ps
interface hpsq_link_if;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic [4:0] addr;
  logic [7:0] hdata;
  logic hdata_oe;
  logic [7:0] rdata;
  logic rdata_oe;
  logic [7:0] data_bus;
  logic idle_request;
  logic idle_grant;
  logic frame_n;
  logic irdy_n;

  // Undriven data lines float high through board pullups.
  assign data_bus = rdata_oe ? rdata : (hdata_oe ? hdata : 8'hFF);

  modport dev (input cs_n, rd_n, wr_n, addr, data_bus, idle_grant, frame_n, irdy_n,
               output rdata, rdata_oe, idle_request);
  modport host (output cs_n, rd_n, wr_n, addr, hdata, hdata_oe, idle_grant, frame_n, irdy_n,
                input data_bus, idle_request);
endinterface : hpsq_link_if

// ==== design/hpsq_pkg.sv ====
// Package with constants and types shared by both ends of the slot sequencer link.
package hpsq_pkg;
  localparam int NSLOT = 4;
  localparam logic [2:0] REG_GCFG = 3'h0;
  localparam logic [2:0] REG_STAT = 3'h1;
  localparam logic [2:0] REG_CTRL = 3'h2;
  localparam int CB_PWR = 0;
  localparam int CB_RST = 1;
  localparam int CB_CLK = 2;
  localparam int CB_WREQ = 3;
  localparam int CB_WSW = 4;
  localparam int CB_BUS = 5;
  localparam int GB_PROT = 0;
  localparam int GB_SYS66 = 1;
  localparam int GB_SEQ = 2;
  // Revision code value is arbitrary.
  localparam logic [3:0] REV_ID = 4'h5;
  // Serial slave address value is arbitrary.
  localparam logic [6:0] SER_ADDR = 7'h2A;
  localparam logic [2:0] STRAP_CYCLES = 3'h5;
  localparam logic [NSLOT-1:0] SLOT_RST_OFF = 4'h0;
  localparam logic [NSLOT-1:0] SLOT_RST_ON = 4'hF;
  localparam logic [24:0] PIN_RST = 25'h00FF61F;
  localparam logic [10:0] HPIN_RST = 11'h6FF;
  localparam int ISA_WAIT_STATES = 4;
  localparam logic [3:0] ISA_STROBE_LAST = 4'(ISA_WAIT_STATES + 5);
  localparam logic [3:0] ISA_RECOVER_LAST = 4'h4;
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_STAT = 8'h04;
  localparam logic [7:0] APB_ARB = 8'h08;
  localparam int CMD_WRITE = 16;

  typedef enum logic [1:0] {
    SEQ_MANUAL = 2'b00, SEQ_AUTO1 = 2'b01, SEQ_AUTO2 = 2'b10, SEQ_RSVD = 2'b11
  } hpsq_seq_t;
  typedef enum logic [2:0] {
    AS_IDLE = 3'b000, AS_REQ = 3'b001, AS_STEP1 = 3'b010, AS_STEP2 = 3'b011, AS_DONE = 3'b100
  } hpsq_auto_t;
  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000, I2C_DEV = 3'b001, I2C_PTR = 3'b010, I2C_WR = 3'b011, I2C_RD = 3'b100
  } hpsq_i2c_t;
  typedef enum logic [1:0] {
    H_IDLE = 2'b00, H_SETUP = 2'b01, H_STROBE = 2'b10, H_RECOV = 2'b11
  } hpsq_isa_t;
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] data;
    logic smode;
    logic scl;
    logic sda;
    logic sysfast;
    logic [1:0] cardfast;
    logic grant;
    logic frame_n;
    logic irdy_n;
    logic cs_n;
    logic rd_n;
    logic wr_n;
  } hpsq_pins_t;
  typedef struct packed {
    logic frame_n;
    logic irdy_n;
    logic idle_req;
    logic [7:0] data;
  } hpsq_hpins_t;
endpackage : hpsq_pkg

// ==== sim/hpsq_properties.sv ====
// Checker on the link between host and device ends.
`timescale 1ns/1ps
module hpsq_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic rdata_oe,
  input wire logic idle_request,
  input wire logic idle_grant,
  input wire logic frame_n,
  input wire logic irdy_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  property p_one_strb; !(!rd_n && !wr_n); endproperty
  a_one_strb: assert property (p_one_strb) else $error("both strobes low");
  property p_strb_cs; (!rd_n || !wr_n) |-> !cs_n; endproperty
  a_strb_cs: assert property (p_strb_cs) else $error("strobe without select");
  property p_wr_len; $fell(wr_n) |-> !wr_n [*8] ##[1:4] wr_n; endproperty
  a_wr_len: assert property (p_wr_len) else $error("write strobe length");
  property p_oe_on; $rose(rdata_oe) |-> !rd_n && !cs_n; endproperty
  a_oe_on: assert property (p_oe_on) else $error("read drive unasked");
  property p_oe_off; $rose(rd_n) |-> ##[1:7] !rdata_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("read drive held");
  property p_wait; idle_request && !idle_grant |=> idle_request; endproperty
  a_wait: assert property (p_wait) else $error("request dropped ungranted");
  // The pin filters lag, so grant and a high frame_n must be old when the request ends.
  property p_cause; $fell(idle_request) |-> $past(idle_grant, 3) && $past(frame_n, 3); endproperty
  a_cause: assert property (p_cause) else $error("request ended early");
  property p_rel; idle_request && idle_grant && frame_n && irdy_n |-> ##[1:12] !idle_request;
  endproperty
  a_rel: assert property (p_rel) else $error("request not released");
  c_auto: cover property ($fell(idle_request));
  c_read: cover property ($rose(rdata_oe));
  c_write: cover property ($fell(wr_n));
endmodule : hpsq_properties

// ==== sim/tb.sv ====
// Testbench joining host and device ends over the link.
`timescale 1ns/1ps
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, frame_n = 1'b1, irdy_n = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er;
  logic [3:0] pwr, rst, clk_en, bus, wsw, wreq;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  hpsq_link_if link();
  hpsq_dev_end hpsq_dev_end_i (.link(link), .pclk(pclk), .presetn(presetn),
    .serial_mode(1'b0), .scl(1'b1), .sda_in(1'b1), .sda_oe(),
    .system_fast_clock_enable(1'b1), .card_fast_capable(2'h1), .slot_power_out(pwr),
    .slot_reset_out(rst), .slot_clock_enable_out(clk_en), .bus_switch_enable_out(bus),
    .wide_switch_enable_out(wsw), .slot_wide_request(wreq));
  hpsq_host_end hpsq_host_end_i (.link(link), .pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pci_frame_n(frame_n), .pci_irdy_n(irdy_n));
  hpsq_properties hpsq_properties_i (.pclk(pclk), .presetn(presetn), .cs_n(link.cs_n),
    .rd_n(link.rd_n), .wr_n(link.wr_n), .rdata_oe(link.rdata_oe),
    .idle_request(link.idle_request), .idle_grant(link.idle_grant),
    .frame_n(link.frame_n), .irdy_n(link.irdy_n));
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Each byte access waits for the host to go idle, so only one is ever in flight.
  task lnk(input logic w, input logic [4:0] a, input logic [7:0] d);
    apb(1'b1, hpsq_pkg::APB_CMD, {15'h0, w, d, 3'h0, a});
    rd = 32'h1;
    while (rd[0] !== 1'b0) apb(1'b0, hpsq_pkg::APB_STAT, 32'h0);
    @(negedge pclk);
  endtask : lnk
  task t_reset();
    chk("pwr", pwr, 4'h0);
    chk("rst", rst, 4'hF);
    chk("bus", bus, 4'h0);
    chk("wreq", wreq, 4'hF);
    apb(1'b0, 8'h10, 32'h0);
    chk("slverr", er, 1'b1);
    lnk(1'b0, 5'h00, 8'h00);
    chk("cfg", rd[15:8], {hpsq_pkg::REV_ID, 4'h2});
    lnk(1'b0, 5'h02, 8'h00);
    chk("ctl", rd[15:8], 8'h3C);
  endtask : t_reset
  task t_manual();
    lnk(1'b1, 5'h02, 8'h39);
    chk("pwr0", pwr[0], 1'b1);
    lnk(1'b0, 5'h01, 8'h00);
    chk("fast0", rd[15:8], 8'h01);
    lnk(1'b0, 5'h11, 8'h00);
    chk("fast2", rd[15:8], 8'h00);
    lnk(1'b1, 5'h02, 8'h19);
    chk("bus0", bus[0], 1'b1);
    chk("ireq", link.idle_request, 1'b0);
  endtask : t_manual
  task t_auto1();
    lnk(1'b1, 5'h00, 8'h04);
    lnk(1'b0, 5'h08, 8'h00);
    chk("mode", rd[15:8], {hpsq_pkg::REV_ID, 4'h6});
    lnk(1'b1, 5'h0A, 8'h21);
    chk("wreq1", wreq[1], 1'b0);
    chk("wsw1", wsw[1], 1'b1);
    @(posedge pclk);
    frame_n <= 1'b0;
    lnk(1'b1, 5'h0A, 8'h01);
    repeat (20) @(negedge pclk);
    chk("busy", bus[1], 1'b0);
    chk("ireq1", link.idle_request, 1'b1);
    @(posedge pclk);
    frame_n <= 1'b1;
    while (bus[1] !== 1'b1) @(negedge pclk);
    chk("rst1a", rst[1], 1'b1);
    @(negedge pclk);
    chk("rst1b", rst[1], 1'b0);
    chk("wreq1b", wreq[1], 1'b1);
    chk("wsw1b", wsw[1], 1'b0);
  endtask : t_auto1
  task t_auto2();
    lnk(1'b1, 5'h00, 8'h08);
    lnk(1'b1, 5'h12, 8'h21);
    @(posedge pclk);
    irdy_n <= 1'b0;
    lnk(1'b1, 5'h12, 8'h01);
    repeat (20) @(negedge pclk);
    chk("irdy2", rst[2], 1'b1);
    @(posedge pclk);
    irdy_n <= 1'b1;
    while (rst[2] !== 1'b0) @(negedge pclk);
    chk("bus2a", bus[2], 1'b0);
    @(negedge pclk);
    chk("bus2b", bus[2], 1'b1);
    chk("wreq2", wreq[2], 1'b1);
  endtask : t_auto2
  task t_disc();
    lnk(1'b1, 5'h0A, 8'h31);
    while (pwr[1] !== 1'b0) @(negedge pclk);
    chk("bus1", bus[1], 1'b0);
    chk("clk1", clk_en[1], 1'b0);
    chk("wsw1c", wsw[1], 1'b1);
  endtask : t_disc
  task finish_test();
    if (fail_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    @(negedge pclk);
    t_reset();
    apb(1'b1, hpsq_pkg::APB_ARB, 32'h1);
    t_manual();
    t_auto1();
    t_auto2();
    t_disc();
    finish_test();
  end
endmodule : tb
